// *** src/dsa_cfg.svh ***
// Bit positions, register selects and timing constants of the diskette sense/access block
`ifndef DSA_CFG_SVH
`define DSA_CFG_SVH
// Port selects on the parallel bus
`define DSA_SEL_XFER_STATUS   2'h0
`define DSA_SEL_POS_CONTROL   2'h1
`define DSA_SEL_POS_STATUS    2'h2
`define DSA_SEL_XFER_CONTROL  2'h3
// Transfer control bits
`define DSA_XC_START_WRITE    0
`define DSA_XC_START_READ     1
`define DSA_XC_DIAG1          2
`define DSA_XC_DIAG2          3
`define DSA_XC_ERASE          4
`define DSA_XC_WRITE_AM       6
`define DSA_XC_RESET          7
// Positioning control bits
`define DSA_PC_CLR_MEDIA      0
`define DSA_PC_MFM            1
`define DSA_PC_FILTER         2
`define DSA_PC_INNER          3
`define DSA_PC_HEAD_LOAD      4
`define DSA_PC_HEAD_SEL       5
`define DSA_PC_PHASE_A        6
`define DSA_PC_PHASE_B        7
// Reset values
`define DSA_POS_RESET         8'h00
// Timing
`define DSA_CLK_HZ            50000000
`define DSA_NO_INDEX_MS       200
`define DSA_LONG_INDEX_MS     16
`define DSA_NO_INDEX_CYC      ((`DSA_CLK_HZ / 1000) * `DSA_NO_INDEX_MS)
`define DSA_LONG_INDEX_CYC    ((`DSA_CLK_HZ / 1000) * `DSA_LONG_INDEX_MS)
`endif

// *** src/dsa_pkg.sv ***
// Types shared by the diskette sense/access block
package dsa_pkg;
  typedef enum logic [1:0] {MODE_ACCESS, MODE_READ, MODE_WRITE} dsa_mode_e;
  typedef struct packed {
    logic [1:0] sel;
    logic       wrStb;
    logic [7:0] data;
  } dsa_bus_s;
  typedef struct packed {
    dsa_mode_e  mode;
    logic       diag1;
    logic       diag2;
    logic       erase;
    logic       crcErr;
    logic       overrun;
    logic       newMedia;
    logic [7:0] pos;
    logic [1:0] idleIdx;
    logic [23:0] noIdxCnt;
    logic [23:0] longIdxCnt;
    logic [1:0] idxSync;
    logic [1:0] sideSync;
    logic [1:0] coverSync;
    logic       idxPrev;
    logic [7:0] rdData;
  } dsa_state_s;
endpackage

// *** src/dsa_sense_access.sv ***
// Diskette adapter transfer status and drive positioning register block
`timescale 1ns/1ps
`include "dsa_cfg.svh"
// How it works
// - Transfer status bit 0 reads one while in write mode.
// - Transfer status bit 1 reads one while in read mode.
// - Transfer status bit 2 reads one when either diagnostic latch is set.
// - Transfer status bit 3 follows the synchronised index sensor.
// - Transfer status bit 4 shows the erase gate latch.
// - Bit 5 shows double-sided media; software samples it after index check.
// - Bit 6 sets when media CRC disagrees with computed CRC.
// - Bit 7 sets on missed byte service; forces access mode.
// - Control bit 0 clears media-changed latch; cover opening sets it.
// - Control bit 1 selects FM (zero) or MFM (one).
// - Control bit 4 drives head load output.
// - Two index pulses with no command unload the heads.
// - Control bit 5 selects head 1 or head 0.
// - Phase lines: 0=bit6, 1=bit7, 2=not bit6, 3=not bit7.
// - No index 200 ms or index over 16 ms sets media-changed.
// - Positioning status bit 1 shows MFM encoding.
// - Positioning status bits 2 and 3 show the two zone latches.
// - Status bit 4 shows head loaded, bit 5 selected side.
// - Status bits 6 and 7 show stepper phase lines.
// - Transfer control bit 7 ends activity, back to access mode.
module dsa_sense_access #(
  parameter int NO_INDEX_CYC   = `DSA_NO_INDEX_CYC,
  parameter int LONG_INDEX_CYC = `DSA_LONG_INDEX_CYC
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              srst,
  // Host parallel bus
  input  wire dsa_pkg::dsa_bus_s busOut,
  output logic [7:0]             busIn,
  // Events from the data path, same clock
  input  wire logic              crcMismatch,
  input  wire logic              byteReq,
  input  wire logic              byteServiced,
  // Drive sensors, asynchronous
  input  wire logic              indexSensor,
  input  wire logic              doubleSided,
  input  wire logic              coverOpen,
  // Drive controls
  output logic                   mfmSelect,
  output logic                   filterZone,
  output logic                   innerZone,
  output logic                   headLoad,
  output logic                   headSelect,
  output logic [3:0]             phaseLine,
  output logic                   eraseGate,
  output logic                   writeMode,
  output logic                   readMode
);

  dsa_pkg::dsa_state_s st_reg;
  dsa_pkg::dsa_state_s st_next;
  logic                pendReq_reg;
  logic                pendReq_next;

  // Transfer status byte assembly
  function automatic logic [7:0] xferByte(input dsa_pkg::dsa_state_s s);
    xferByte = {s.overrun,
                s.crcErr,
                s.sideSync[1],
                s.erase,
                s.idxSync[1],
                s.diag1 | s.diag2,
                s.mode == dsa_pkg::MODE_READ,
                s.mode == dsa_pkg::MODE_WRITE};
  endfunction

  // Positioning status byte: bit 0 media change, the rest mirror control
  function automatic logic [7:0] posByte(input dsa_pkg::dsa_state_s s);
    posByte = {s.pos[7:1], s.newMedia};
  endfunction

  logic idxRise;
  logic wrXfer;
  logic wrPos;
  assign idxRise = st_reg.idxSync[1] & ~st_reg.idxPrev;
  assign wrXfer  = busOut.wrStb && busOut.sel == `DSA_SEL_XFER_CONTROL;
  assign wrPos   = busOut.wrStb && busOut.sel == `DSA_SEL_POS_CONTROL;

  // Next-state logic; reads never touch state
  always_comb begin
    st_next = st_reg;
    pendReq_next = pendReq_reg;
    // Two-flop synchronisers for drive sensors
    st_next.idxSync   = {st_reg.idxSync[0], indexSensor};
    st_next.sideSync  = {st_reg.sideSync[0], doubleSided};
    st_next.coverSync = {st_reg.coverSync[0], coverOpen};
    st_next.idxPrev   = st_reg.idxSync[1];
    // Transfer control writes
    if (wrXfer) begin
      if (busOut.data[`DSA_XC_START_WRITE]) begin
        st_next.mode = dsa_pkg::MODE_WRITE;
      end
      if (busOut.data[`DSA_XC_START_READ]) begin
        st_next.mode = dsa_pkg::MODE_READ;
      end
      st_next.diag1 = busOut.data[`DSA_XC_DIAG1];
      st_next.diag2 = busOut.data[`DSA_XC_DIAG2];
      // Write AM also turns the erase gate on
      st_next.erase = busOut.data[`DSA_XC_ERASE] | busOut.data[`DSA_XC_WRITE_AM];
      if (busOut.data[`DSA_XC_RESET]) begin
        st_next.mode    = dsa_pkg::MODE_ACCESS;
        st_next.diag1   = 1'b0;
        st_next.diag2   = 1'b0;
        st_next.overrun = 1'b0;
        st_next.crcErr  = 1'b0;
        pendReq_next    = 1'b0;
      end
    end
    // CRC compare failure is sticky until reset command
    if (crcMismatch) begin
      st_next.crcErr = 1'b1;
    end
    // Overrun: a new byte request while the last is unserviced
    if (byteServiced) begin
      pendReq_next = 1'b0;
    end
    if (byteReq) begin
      if (pendReq_reg && !byteServiced) begin
        st_next.overrun = 1'b1;
        st_next.mode    = dsa_pkg::MODE_ACCESS;
        st_next.diag1   = 1'b0;
        st_next.diag2   = 1'b0;
      end
      pendReq_next = 1'b1;
    end
    // Positioning control write; bit 0 is a clear strobe, not stored
    if (wrPos) begin
      st_next.pos = {busOut.data[7:1], 1'b0};
      if (busOut.data[`DSA_PC_CLR_MEDIA]) begin
        st_next.newMedia = 1'b0;
      end
    end
    // Idle head unload: any command restarts the index count
    if (busOut.wrStb) begin
      st_next.idleIdx = 2'h0;
    end else if (idxRise && st_reg.pos[`DSA_PC_HEAD_LOAD]) begin
      if (st_reg.idleIdx == 2'h1) begin
        st_next.pos[`DSA_PC_HEAD_LOAD] = 1'b0;
        st_next.idleIdx = 2'h0;
      end else begin
        st_next.idleIdx = st_reg.idleIdx + 2'h1;
      end
    end
    // Index watchdogs; counters saturate at their limits
    if (idxRise) begin
      st_next.noIdxCnt = 24'h00_0000;
    end else if (st_reg.noIdxCnt < 24'(NO_INDEX_CYC)) begin
      st_next.noIdxCnt = st_reg.noIdxCnt + 24'h00_0001;
    end
    if (!st_reg.idxSync[1]) begin
      st_next.longIdxCnt = 24'h00_0000;
    end else if (st_reg.longIdxCnt < 24'(LONG_INDEX_CYC)) begin
      st_next.longIdxCnt = st_reg.longIdxCnt + 24'h00_0001;
    end
    // Setting events win over the software clear
    if (st_reg.coverSync[1]
        || st_reg.noIdxCnt == 24'(NO_INDEX_CYC) - 24'h00_0001
        || st_reg.longIdxCnt == 24'(LONG_INDEX_CYC)) begin
      st_next.newMedia = 1'b1;
    end
    // Read data registered from selected byte
    case (busOut.sel)
      `DSA_SEL_XFER_STATUS: st_next.rdData = xferByte(st_reg);
      `DSA_SEL_POS_STATUS:  st_next.rdData = posByte(st_reg);
      default:              st_next.rdData = 8'h00;
    endcase
  end

  // State register; reset returns to access mode
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg      <= '0;
      pendReq_reg <= 1'b0;
    end else begin
      st_reg      <= st_next;
      pendReq_reg <= pendReq_next;
    end
  end

  // Outputs straight from state
  assign busIn      = st_reg.rdData;
  assign mfmSelect  = st_reg.pos[`DSA_PC_MFM];
  assign filterZone = st_reg.pos[`DSA_PC_FILTER];
  assign innerZone  = st_reg.pos[`DSA_PC_INNER];
  assign headLoad   = st_reg.pos[`DSA_PC_HEAD_LOAD];
  assign headSelect = st_reg.pos[`DSA_PC_HEAD_SEL];
  assign phaseLine  = {~st_reg.pos[`DSA_PC_PHASE_B], ~st_reg.pos[`DSA_PC_PHASE_A],
                       st_reg.pos[`DSA_PC_PHASE_B], st_reg.pos[`DSA_PC_PHASE_A]};
  assign eraseGate  = st_reg.erase;
  assign writeMode  = st_reg.mode == dsa_pkg::MODE_WRITE;
  assign readMode   = st_reg.mode == dsa_pkg::MODE_READ;

endmodule

// *** tb/dsa_sense_access_monitor.sv ***
// Port-level assertions for the sense/access block
`timescale 1ns/1ps
module dsa_sense_access_monitor (
  // Clock, reset and host bus
  input wire logic              mclk,
  input wire logic              srst,
  input wire dsa_pkg::dsa_bus_s busOut,
  input wire logic [7:0]        busIn,
  // Data path events
  input wire logic              byteReq,
  input wire logic              byteServiced,
  // Drive controls
  input wire logic              mfmSelect,
  input wire logic              filterZone,
  input wire logic              innerZone,
  input wire logic              headLoad,
  input wire logic              headSelect,
  input wire logic [3:0]        phaseLine,
  input wire logic              eraseGate,
  input wire logic              writeMode,
  input wire logic              readMode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // Write qualifiers, shared so the mfm, hload, hsel, hold and rst properties stay one line
  wire pcWr = busOut.wrStb && busOut.sel == 2'h1;
  wire xcWr = busOut.wrStb && busOut.sel == 2'h3;
  property p_mfm; pcWr |=> mfmSelect == $past(busOut.data[1]); endproperty
  a_mfm: assert property (p_mfm) else $error("mfmSelect wrong");
  property p_hload; pcWr |=> headLoad == $past(busOut.data[4]); endproperty
  a_hload: assert property (p_hload) else $error("headLoad wrong");
  property p_hsel; pcWr |=> headSelect == $past(busOut.data[5]); endproperty
  a_hsel: assert property (p_hsel) else $error("headSelect wrong");
  property p_phase; pcWr |=> phaseLine == {~$past(busOut.data[7:6]), $past(busOut.data[7:6])};
  endproperty
  a_phase: assert property (p_phase) else $error("phaseLine wrong");
  // Phases move only on a control write, otherwise the stepper would drift
  property p_hold; !pcWr |=> $stable(phaseLine); endproperty
  a_hold: assert property (p_hold) else $error("phaseLine moved");
  property p_pstat; busOut.sel == 2'h2 && !$past(srst) |=> busIn[7:1] ==
    $past({phaseLine[1:0], headSelect, headLoad, innerZone, filterZone, mfmSelect}); endproperty
  a_pstat: assert property (p_pstat) else $error("pos status wrong");
  property p_xstat; busOut.sel == 2'h0 && !$past(srst) |=>
    {busIn[4], busIn[1:0]} == $past({eraseGate, readMode, writeMode}); endproperty
  a_xstat: assert property (p_xstat) else $error("xfer status wrong");
  property p_ovr; (byteReq && !byteServiced) ##1 (byteReq && !byteServiced) |->
    ##[1:2] (!readMode && !writeMode); endproperty
  a_ovr: assert property (p_ovr) else $error("overrun kept mode");
  property p_rst; xcWr && busOut.data[7] |=> !readMode && !writeMode; endproperty
  a_rst: assert property (p_rst) else $error("reset kept mode");
endmodule
bind dsa_sense_access dsa_sense_access_monitor u_mon (.*);

// *** tb/dsa_drive_model.sv ***
// Behavioural drive: spinning media with index hole and media-type sensor
`timescale 1ns/1ps
module dsa_drive_model #(
  parameter int PERIOD = 100,
  parameter int WIDTH  = 8
) (
  // Clock and bench controls
  input  wire logic mclk,
  input  wire logic spin,
  input  wire logic stuckIdx,
  input  wire logic twoSided,
  // Sensor lines
  output logic      indexSensor,
  output logic      doubleSided
);
  int cnt = 0;
  // Free-running rotation position
  always @(posedge mclk) begin
    cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
  end
  // Hole passes once a turn; a stuck sensor models a stalled disk
  assign indexSensor = stuckIdx || (spin && cnt < WIDTH);
  assign doubleSided = twoSided;
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the sense/access block
`timescale 1ns/1ps
module tb_top;
  logic              mclk = 0;
  logic              srst = 1;
  dsa_pkg::dsa_bus_s busOut = '0;
  logic              crcMismatch = 0, byteReq = 0, byteServiced = 0, coverOpen = 0;
  logic              spin = 0, stuckIdx = 0, twoSided = 0;
  logic              indexSensor, doubleSided, mfmSelect, filterZone, innerZone;
  logic              headLoad, headSelect, eraseGate, writeMode, readMode;
  logic [3:0]        phaseLine;
  logic [7:0]        busIn, v, d;
  logic [1:0]        steps [5] = '{2'b11, 2'b10, 2'b00, 2'b01, 2'b11};
  logic [7:0]        xw [8] = '{8'h01, 8'h80, 8'h02, 8'h80, 8'h04, 8'h08, 8'h10, 8'h40};
  logic [7:0]        xe [8] = '{8'h01, 8'h00, 8'h02, 8'h00, 8'h04, 8'h04, 8'h10, 8'h10};
  int                err_count = 0, checks_done = 0;
  // Short counts keep the run small
  dsa_sense_access #(.NO_INDEX_CYC(200), .LONG_INDEX_CYC(20)) uut (.*);
  dsa_drive_model drv (.*);
  initial forever #10 mclk = ~mclk;
  task automatic wr(logic [1:0] s, logic [7:0] x);
    @(posedge mclk);
    busOut <= '{sel: s, wrStb: 1'b1, data: x};
    @(posedge mclk);
    busOut.wrStb <= 1'b0;
  endtask
  // Read data lags the select by one edge
  task automatic rd(logic [1:0] s);
    @(posedge mclk);
    busOut.sel <= s;
    @(posedge mclk);
    @(negedge mclk);
    v = busIn;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    if (err_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32));
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    rd(2'h2);
    chk("posStatus", 8'h00, v);
    // Bit 0 is a strobe and reads back as the media latch, so it is masked
    repeat (12) begin
      d = 8'($urandom) & 8'hFE;
      wr(2'h1, d);
      rd(2'h2);
      chk("posStatus", d, v & 8'hFE);
    end
    foreach (steps[k]) begin
      wr(2'h1, {steps[k], 6'h00});
      @(negedge mclk);
      chk("phaseLine", {4'h0, ~steps[k], steps[k]}, {4'h0, phaseLine});
    end
    // Head at track 60 or above: software sets both zone latches
    wr(2'h1, 8'h0C);
    @(negedge mclk);
    chk("zone", 8'h03, {6'h00, innerZone, filterZone});
    // Between tracks 42 and 59 only the inner-zone latch stays set
    wr(2'h1, 8'h08);
    @(negedge mclk);
    chk("zone", 8'h02, {6'h00, innerZone, filterZone});
    repeat (210) @(posedge mclk);
    rd(2'h2);
    chk("noIndex", 8'h01, v & 8'h01);
    wr(2'h1, 8'h01);
    rd(2'h2);
    chk("mediaClr", 8'h00, v & 8'h01);
    coverOpen <= 1'b1;
    wr(2'h1, 8'h00);
    coverOpen <= 1'b0;
    rd(2'h2);
    chk("cover", 8'h01, v & 8'h01);
    wr(2'h1, 8'h01);
    stuckIdx <= 1'b1;
    repeat (30) @(posedge mclk);
    stuckIdx <= 1'b0;
    rd(2'h2);
    chk("longIndex", 8'h01, v & 8'h01);
    spin <= 1'b1;
    wr(2'h1, 8'h11);
    repeat (250) @(posedge mclk);
    rd(2'h2);
    chk("idleUnload", 8'h00, v & 8'h11);
    foreach (xw[k]) begin
      wr(2'h3, xw[k]);
      rd(2'h0);
      chk("xferStatus", xe[k], v & 8'h17);
    end
    crcMismatch <= 1'b1;
    wr(2'h3, 8'h02);
    crcMismatch <= 1'b0;
    byteReq <= 1'b1;
    repeat (2) @(posedge mclk);
    byteReq <= 1'b0;
    rd(2'h0);
    chk("overrun", 8'hC0, v & 8'hC3);
    wr(2'h3, 8'h80);
    rd(2'h0);
    chk("errClr", 8'h00, v & 8'hC0);
    // A request serviced in the cycle of the next one is no overrun
    wr(2'h3, 8'h02);
    byteReq <= 1'b1;
    @(posedge mclk);
    byteServiced <= 1'b1;
    @(posedge mclk);
    byteReq <= 1'b0;
    byteServiced <= 1'b0;
    rd(2'h0);
    chk("serviced", 8'h02, v & 8'hC3);
    twoSided <= 1'b1;
    for (int i = 0; indexSensor !== 1'b1; i++) begin
      if (i == 400) begin
        err_count++;
        wrap_up();
      end
      @(posedge mclk);
    end
    rd(2'h0);
    chk("index", 8'h28, v & 8'h28);
    wrap_up();
  end
endmodule
